// *** gcm_pkg.sv ***
// Purpose: Shared constants for the governor contact mode selector
// Assumes: 25 MHz clock, contact inputs are raw pins
// Notes: Debounce time is given in microseconds and turned into cycles
package gcm_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned DEBOUNCE_US = 40; // Raise for longer bounce
  localparam int unsigned DEBOUNCE_CYCLES =
    (DEBOUNCE_US * (CLK_HZ / 1000000));
  localparam int unsigned DB_W = 18;
  localparam int unsigned REF_W = 16;
  localparam int unsigned PCT_W = 8;
  localparam int unsigned RATE_W = 16;
  localparam logic [REF_W-1:0] REF_RST = 16'h0000;
  localparam logic [PCT_W-1:0] PCT_FULL = 8'h64;
  typedef enum logic [1:0] {
    GCM_MODE_DROOP,
    GCM_MODE_ISOCH,
    GCM_MODE_BASE
  } gcm_mode_t;
  typedef enum logic [1:0] {
    GCM_RAMP_NONE,
    GCM_RAMP_UNLOAD,
    GCM_RAMP_BASE,
    GCM_RAMP_SHARE
  } gcm_ramp_t;
endpackage

// *** gcm_debounce.sv ***
// Purpose: Synchronise and debounce one contact input
// Assumes: Input is asynchronous to mclk_in
// Notes: Output changes only after the input is stable for the count
`timescale 1ns/1ns
module gcm_debounce #(
  parameter int unsigned COUNT = 250000
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Raw contact and clean level
  input wire logic raw_in,
  output logic clean_out
);
  import gcm_pkg::*;
  logic sync_a;
  logic sync_b;
  logic [DB_W-1:0] cnt;
  logic [DB_W-1:0] next_cnt;
  logic next_clean;

  // Count while the synced level differs from the clean level
  always_comb begin
    next_cnt = '0;
    next_clean = clean_out;
    if (sync_b != clean_out) begin
      if (cnt >= DB_W'(COUNT - 1)) begin
        next_clean = sync_b;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  // Two-stage synchroniser and debounce state
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      cnt <= '0;
      clean_out <= 1'b0;
    end else begin
      sync_a <= raw_in;
      sync_b <= sync_a;
      cnt <= next_cnt;
      clean_out <= next_clean;
    end
  end
endmodule

// *** gcm_mode_selector.sv ***
// Purpose: Contact-driven mode selection for an engine speed governor
// Assumes: Contacts are high when closed; setpoints are static inputs
// Notes: Speed reference is a plain unsigned value set directly; load reference is a plain unsigned ramp
//
// Overview of operation
// - Base-load and breaker contacts pick base-load, isochronous or droop mode.
// - In load modes, opening unload contact ramps load to unload trip level.
// - Reclosing unload contact in load mode ramps back to base or sharing.
// - In droop, opening unload contact resets speed reference to rated at once.
// - Droop speed reference is rated plus droop percent times load fraction.
// - All three closed ramps load to base-load setpoint and holds it.
// - Breaker open: main dynamics, droop, no load control; closed: opposite.
// - Zero droop setting makes droop mode act isochronously.
// - Breaker steers raise, lower, remote to speed or load; gates sharing.
// - Raise and lower together select remote setting, disabling both.
// - Raise or lower in load mode cancels unload or base-load ramps.
`timescale 1ns/1ns
module gcm_mode_selector (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Contacts, high when closed
  input wire logic unload_reset_in,
  input wire logic base_load_in,
  input wire logic breaker_auxiliary_in,
  input wire logic raise_in,
  input wire logic lower_in,
  input wire logic idle_rated_in,
  input wire logic breaker_open_in,
  // Setpoints and measured load
  input wire logic [gcm_pkg::REF_W-1:0] rated_speed_in,
  input wire logic [gcm_pkg::PCT_W-1:0] droop_pct_in,
  input wire logic [gcm_pkg::PCT_W-1:0] load_pct_in,
  input wire logic [gcm_pkg::REF_W-1:0] base_ref_in,
  input wire logic [gcm_pkg::REF_W-1:0] share_ref_in,
  input wire logic [gcm_pkg::REF_W-1:0] unload_trip_in,
  input wire logic [gcm_pkg::RATE_W-1:0] load_rate_in,
  input wire logic [gcm_pkg::RATE_W-1:0] unload_rate_in,
  // Mode and steering outputs
  output gcm_pkg::gcm_mode_t mode_out,
  output logic aux_dynamics_out,
  output logic load_ctrl_en_out,
  output logic remote_mode_out,
  output logic raise_speed_out,
  output logic lower_speed_out,
  output logic raise_load_out,
  output logic lower_load_out,
  output logic remote_to_load_out,
  output logic share_lines_closed_out,
  output logic breaker_open_act_out,
  output logic idle_rated_act_out,
  output gcm_pkg::gcm_ramp_t ramp_out,
  output logic [gcm_pkg::REF_W-1:0] speed_ref_out,
  output logic [gcm_pkg::REF_W-1:0] load_ref_out
);
  import gcm_pkg::*;
  localparam int NC = 7;
  logic [NC-1:0] clean;
  logic unl, bl, cb, rs, lw, ir, bo;
  logic unl_q;
  logic unl_fall;
  logic unl_rise;

  // Debounce every contact input
  genvar gi;
  logic [NC-1:0] pins;
  assign pins = {breaker_open_in, idle_rated_in, lower_in, raise_in,
                 breaker_auxiliary_in, base_load_in, unload_reset_in};
  generate
    for (gi = 0; gi < NC; gi++) begin : g_db
      gcm_debounce #(.COUNT(DEBOUNCE_CYCLES)) u_db (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .raw_in(pins[gi]),
        .clean_out(clean[gi])
      );
    end
  endgenerate
  assign {bo, ir, lw, rs, cb, bl, unl} = clean;

  // Edges on the unload/reset contact; both levels reset low, so a
  // contact closed at power-up gives one rise once it has settled
  assign unl_fall = unl_q && !unl;
  assign unl_rise = !unl_q && unl;

  gcm_mode_t next_mode;
  gcm_ramp_t next_ramp;
  logic [REF_W-1:0] next_speed_ref;
  logic [REF_W-1:0] next_load_ref;
  logic [REF_W-1:0] target;
  logic [REF_W-1:0] rate;
  logic [REF_W+PCT_W-1:0] droop_prod;
  logic [REF_W+2*PCT_W-1:0] droop_off;
  logic [REF_W:0] up_sum;
  logic remote;
  logic load_mode;

  // Droop offset: rated * droop% * load% / 10000
  always_comb begin
    droop_prod = rated_speed_in * droop_pct_in;
    droop_off = (droop_prod * load_pct_in) / (PCT_FULL * PCT_FULL);
  end

  // Mode decode, ramp control and reference update
  // The droop reset is a one-cycle jump: the droop offset then follows
  // the measured load again, so the reference stays at rated only once
  // the engine has shed its load
  always_comb begin
    remote = rs && lw;
    if (cb && bl) begin
      next_mode = GCM_MODE_BASE;
    end else if (cb) begin
      next_mode = GCM_MODE_ISOCH;
    end else begin
      next_mode = GCM_MODE_DROOP;
    end
    load_mode = cb;
    next_ramp = ramp_out;
    next_speed_ref = speed_ref_out;
    next_load_ref = load_ref_out;
    if (!load_mode) begin
      next_ramp = GCM_RAMP_NONE;
      if (unl_fall) begin
        next_speed_ref = rated_speed_in;
      end else if (droop_pct_in == '0) begin
        next_speed_ref = rated_speed_in;
      end else if (!remote && (rs || lw)) begin
        next_speed_ref = speed_ref_out;
      end else begin
        next_speed_ref = REF_W'(rated_speed_in + droop_off);
      end
    end else begin
      next_speed_ref = rated_speed_in;
      if (!remote && (rs || lw)) begin
        next_ramp = GCM_RAMP_NONE;
      end else if (unl_fall || (!unl && ramp_out != GCM_RAMP_NONE)) begin
        next_ramp = GCM_RAMP_UNLOAD;
      end else if (unl_rise || (unl && bl && ramp_out == GCM_RAMP_NONE
                   && mode_out != GCM_MODE_BASE)) begin
        next_ramp = bl ? GCM_RAMP_BASE : GCM_RAMP_SHARE;
      end else if (unl && ramp_out == GCM_RAMP_BASE && !bl) begin
        next_ramp = GCM_RAMP_SHARE;
      end else if (unl && ramp_out == GCM_RAMP_SHARE && bl) begin
        next_ramp = GCM_RAMP_BASE;
      end
    end
    case (next_ramp)
      GCM_RAMP_UNLOAD: target = unload_trip_in;
      GCM_RAMP_BASE: target = base_ref_in;
      GCM_RAMP_SHARE: target = share_ref_in;
      default: target = load_ref_out;
    endcase
    rate = (target < load_ref_out) ? unload_rate_in : load_rate_in;
    up_sum = {1'b0, load_ref_out} + {1'b0, rate};
    if (load_mode && next_ramp != GCM_RAMP_NONE) begin
      if (target > load_ref_out) begin
        next_load_ref = (up_sum >= {1'b0, target}) ? target
                        : up_sum[REF_W-1:0];
      end else if (load_ref_out - target <= rate) begin
        next_load_ref = target;
      end else begin
        next_load_ref = load_ref_out - rate;
      end
    end
  end

  // Steering of raise, lower and breaker-gated functions
  logic next_raise_speed;
  logic next_lower_speed;
  logic next_raise_load;
  logic next_lower_load;
  logic next_brk_act;
  always_comb begin
    next_raise_speed = !cb && rs && !remote;
    next_lower_speed = !cb && lw && !remote;
    next_raise_load = cb && rs && !remote;
    next_lower_load = cb && lw && !remote;
    next_brk_act = cb && bo;
  end

  // Register mode, ramp, references and steering outputs
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      unl_q <= 1'b0;
      mode_out <= GCM_MODE_DROOP;
      ramp_out <= GCM_RAMP_NONE;
      speed_ref_out <= REF_RST;
      load_ref_out <= REF_RST;
      aux_dynamics_out <= 1'b0;
      load_ctrl_en_out <= 1'b0;
      remote_mode_out <= 1'b0;
      raise_speed_out <= 1'b0;
      lower_speed_out <= 1'b0;
      raise_load_out <= 1'b0;
      lower_load_out <= 1'b0;
      remote_to_load_out <= 1'b0;
      share_lines_closed_out <= 1'b0;
      breaker_open_act_out <= 1'b0;
      idle_rated_act_out <= 1'b0;
    end else begin
      unl_q <= unl;
      mode_out <= next_mode;
      ramp_out <= next_ramp;
      speed_ref_out <= next_speed_ref;
      load_ref_out <= next_load_ref;
      aux_dynamics_out <= cb;
      load_ctrl_en_out <= cb;
      remote_mode_out <= remote;
      raise_speed_out <= next_raise_speed;
      lower_speed_out <= next_lower_speed;
      raise_load_out <= next_raise_load;
      lower_load_out <= next_lower_load;
      remote_to_load_out <= cb;
      share_lines_closed_out <= cb;
      breaker_open_act_out <= next_brk_act;
      idle_rated_act_out <= ir;
    end
  end
endmodule

// *** gcm_chk_props.sv ***
// Purpose: Port assertions for the mode selector
// Assumes: One clock, async active-low reset
// Notes: Bound from the testbench file
`timescale 1ns/1ns
module gcm_chk
  import gcm_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Watched inputs
  input wire logic [REF_W-1:0] rated_speed_in,
  input wire logic [PCT_W-1:0] droop_pct_in,
  input wire logic [REF_W-1:0] base_ref_in,
  input wire logic [REF_W-1:0] unload_trip_in,
  // Watched outputs
  input wire gcm_mode_t mode_out,
  input wire logic aux_dynamics_out,
  input wire logic load_ctrl_en_out,
  input wire logic remote_mode_out,
  input wire logic raise_speed_out,
  input wire logic lower_speed_out,
  input wire logic raise_load_out,
  input wire logic lower_load_out,
  input wire logic share_lines_closed_out,
  input wire logic breaker_open_act_out,
  input wire gcm_ramp_t ramp_out,
  input wire logic [REF_W-1:0] speed_ref_out,
  input wire logic [REF_W-1:0] load_ref_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // Breaker picks dynamics, load control and mode together
  chk_aux_pair: assert property (
    aux_dynamics_out == load_ctrl_en_out) else $error("aux pair");
  chk_mode_map: assert property (
    (mode_out != GCM_MODE_DROOP) == aux_dynamics_out) else $error("mode");
  // Steering of raise, lower and breaker-gated functions
  chk_remote_off: assert property (
    remote_mode_out |-> !(raise_speed_out || lower_speed_out ||
    raise_load_out || lower_load_out)) else $error("remote");
  chk_speed_steer: assert property (
    raise_speed_out || lower_speed_out |-> !aux_dynamics_out)
    else $error("speed steer");
  chk_load_steer: assert property (
    raise_load_out || lower_load_out |-> aux_dynamics_out)
    else $error("load steer");
  chk_ramp_cancel: assert property (
    raise_load_out || lower_load_out |-> ramp_out == GCM_RAMP_NONE)
    else $error("ramp cancel");
  chk_brk_gate: assert property (
    breaker_open_act_out |-> share_lines_closed_out) else $error("gate");
  // References
  chk_zero_droop: assert property (
    mode_out == GCM_MODE_DROOP && droop_pct_in == 8'h00 && !raise_speed_out
    && !lower_speed_out |=> speed_ref_out == $past(rated_speed_in))
    else $error("zero droop");
  chk_unload_fall: assert property (
    ramp_out == GCM_RAMP_UNLOAD && load_ref_out > unload_trip_in |=>
    ramp_out != GCM_RAMP_UNLOAD || load_ref_out < $past(load_ref_out))
    else $error("unload ramp");
  chk_base_hold: assert property (
    ramp_out == GCM_RAMP_BASE && load_ref_out == base_ref_in |=>
    ramp_out != GCM_RAMP_BASE || load_ref_out == base_ref_in)
    else $error("base hold");
endmodule

// *** gcm_contacts.sv ***
// Purpose: Plant switch contacts facing the mode selector
// Assumes: Bench sets wanted levels on clock edges
// Notes: Every change bounces once before settling
`timescale 1ns/1ns
module gcm_contacts (
  // Clock
  input wire logic mclk_in,
  // Wanted levels and contact pins
  input wire logic [6:0] want_in,
  output logic [6:0] pin_out
);
  logic [6:0] last = 7'h00;
  logic [6:0] old = 7'h00;
  logic [1:0] cnt = 2'h0;
  // Contacts move only when asked, with one bounce back
  always @(posedge mclk_in) begin
    if (want_in != last) begin
      old <= last;
      last <= want_in;
      cnt <= 2'h3;
    end else if (cnt != 2'h0) begin
      cnt <= cnt - 2'h1;
    end
    pin_out <= (cnt == 2'h1) ? old : last;
  end
endmodule

// *** testbench.sv ***
// Purpose: Self-checking bench for the mode selector
// Assumes: Full debounce time; contact bits are
// Notes: unload, base, breaker, raise, lower, idle, breaker open
`timescale 1ns/1ns
module testbench;
  import gcm_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [6:0] want = 7'h61;
  wire logic [6:0] pins;
  logic [REF_W-1:0] rated_speed_in = 16'h03E8;
  logic [PCT_W-1:0] droop_pct_in = 8'h05;
  logic [PCT_W-1:0] load_pct_in = 8'h64;
  logic [REF_W-1:0] base_ref_in = 16'h0200;
  logic [REF_W-1:0] share_ref_in = 16'h0100;
  logic [REF_W-1:0] unload_trip_in = 16'h0010;
  logic [RATE_W-1:0] load_rate_in = 16'h0010;
  logic [RATE_W-1:0] unload_rate_in = 16'h0010;
  gcm_mode_t mode_out;
  gcm_ramp_t ramp_out;
  logic aux_dynamics_out, load_ctrl_en_out, remote_mode_out;
  logic raise_speed_out, lower_speed_out, raise_load_out, lower_load_out;
  logic remote_to_load_out, share_lines_closed_out;
  logic breaker_open_act_out, idle_rated_act_out;
  logic [REF_W-1:0] speed_ref_out, load_ref_out;
  int miscompares = 0;
  int samples_checked = 0;
  gcm_contacts i_gcm_contacts(.mclk_in, .want_in(want), .pin_out(pins));
  gcm_mode_selector i_gcm_mode_selector(.mclk_in, .rst_n_in,
    .unload_reset_in(pins[0]), .base_load_in(pins[1]),
    .breaker_auxiliary_in(pins[2]), .raise_in(pins[3]), .lower_in(pins[4]),
    .idle_rated_in(pins[5]), .breaker_open_in(pins[6]), .rated_speed_in,
    .droop_pct_in, .load_pct_in, .base_ref_in, .share_ref_in,
    .unload_trip_in, .load_rate_in, .unload_rate_in, .mode_out,
    .aux_dynamics_out, .load_ctrl_en_out, .remote_mode_out,
    .raise_speed_out, .lower_speed_out, .raise_load_out, .lower_load_out,
    .remote_to_load_out, .share_lines_closed_out, .breaker_open_act_out,
    .idle_rated_act_out, .ramp_out, .speed_ref_out, .load_ref_out);
  // Compare one value
  task automatic check(input string what, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // Move contacts, then wait out sync, debounce and ramps
  task automatic set(input logic [6:0] w);
    @(posedge mclk_in) want <= w;
    repeat (DEBOUNCE_CYCLES + 60) @(posedge mclk_in);
    #1;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Clock and watchdog
  initial begin
    forever #20 mclk_in = ~mclk_in;
  end
  initial begin
    repeat (20 * (DEBOUNCE_CYCLES + 60)) @(posedge mclk_in);
    miscompares++;
    give_verdict();
  end
  // Test sequence
  initial begin : main
    int exp_ref;
    logic hit;
    repeat (3) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    set(7'h61);
    exp_ref = rated_speed_in +
      rated_speed_in * droop_pct_in * load_pct_in / 10000;
    check("mode", mode_out, GCM_MODE_DROOP);
    check("aux", aux_dynamics_out, 1'b0);
    check("ctrl", load_ctrl_en_out, 1'b0);
    check("lines", share_lines_closed_out, 1'b0);
    check("remote", remote_to_load_out, 1'b0);
    check("speed", speed_ref_out, exp_ref[15:0]);
    check("idle", idle_rated_act_out, 1'b1);
    check("brk", breaker_open_act_out, 1'b0);
    @(posedge mclk_in) droop_pct_in <= 8'h00;
    repeat (4) @(posedge mclk_in);
    #1 check("speed0", speed_ref_out, rated_speed_in);
    // Measured load set light (10%) and droop restored before the reset
    @(posedge mclk_in);
    droop_pct_in <= 8'h05;
    load_pct_in <= 8'h0A;
    @(posedge mclk_in) want <= 7'h60;
    hit = 1'b0;
    repeat (DEBOUNCE_CYCLES + 60) begin
      @(posedge mclk_in);
      #1 if (speed_ref_out == rated_speed_in) hit = 1'b1;
    end
    check("reset", hit, 1'b1);
    $display("droop done");
    set(7'h65);
    check("mode", mode_out, GCM_MODE_ISOCH);
    check("ctrl", load_ctrl_en_out, 1'b1);
    check("rated", speed_ref_out, rated_speed_in);
    check("lines", share_lines_closed_out, 1'b1);
    check("remote", remote_to_load_out, 1'b1);
    check("brk", breaker_open_act_out, 1'b1);
    set(7'h67);
    check("mode", mode_out, GCM_MODE_BASE);
    check("load", load_ref_out, base_ref_in);
    set(7'h66);
    check("ramp", ramp_out, GCM_RAMP_UNLOAD);
    check("load", load_ref_out, unload_trip_in);
    set(7'h65);
    check("load", load_ref_out, share_ref_in);
    $display("load modes done");
    set(7'h6D);
    check("ramp", ramp_out, GCM_RAMP_NONE);
    check("load", load_ref_out, share_ref_in);
    check("rload", raise_load_out, 1'b1);
    set(7'h7D);
    check("rmode", remote_mode_out, 1'b1);
    check("rload", raise_load_out, 1'b0);
    check("lload", lower_load_out, 1'b0);
    set(7'h75);
    check("rmode", remote_mode_out, 1'b0);
    check("lload", lower_load_out, 1'b1);
    check("lspeed", lower_speed_out, 1'b0);
    set(7'h69);
    check("rspeed", raise_speed_out, 1'b1);
    check("rload", raise_load_out, 1'b0);
    set(7'h51);
    check("lspeed", lower_speed_out, 1'b1);
    check("lload", lower_load_out, 1'b0);
    check("idle", idle_rated_act_out, 1'b0);
    $display("steering done");
    give_verdict();
  end
endmodule
bind gcm_mode_selector gcm_chk i_gcm_chk(.mclk_in, .rst_n_in,
  .rated_speed_in, .droop_pct_in, .base_ref_in, .unload_trip_in, .mode_out,
  .aux_dynamics_out, .load_ctrl_en_out, .remote_mode_out, .raise_speed_out,
  .lower_speed_out, .raise_load_out, .lower_load_out,
  .share_lines_closed_out, .breaker_open_act_out, .ramp_out,
  .speed_ref_out, .load_ref_out);
